// *** include/rvs_pkg.sv ***
// Purpose: Shared constants and carriers for the reset and vector sequencer
// Assumes: 125 MHz core clock; watchdog oscillator ticks arrive as a pin level
// Notes:   Vector numbers double as priority, lower is higher
package rvs_pkg;

	// Clock and time figures
	localparam int CLK_PERIOD_NS    = 8;
	localparam int PIN_MIN_NS       = 500;
	localparam int PIN_MIN_CYC      = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLK_COUNT_CYC    = 18;

	// Watchdog-oscillator cycle counts of the start-up time-out
	localparam int OSC_CYC_LONG     = 65536;
	localparam int OSC_CYC_MID      = 4096;
	localparam int OSC_CYC_SHORT_BO = 32;
	localparam int OSC_CYC_SHORT    = 8;

	// Start-up delay select encodings
	localparam logic [1:0] SEL_LONG_A = 2'h0;
	localparam logic [1:0] SEL_LONG_B = 2'h1;
	localparam logic [1:0] SEL_MID    = 2'h2;
	localparam logic [1:0] SEL_SHORT  = 2'h3;
	localparam logic [1:0] SEL_RESET  = 2'h0;

	// Reset cause flag positions
	localparam int FLAG_POWERUP  = 0;
	localparam int FLAG_PIN      = 1;
	localparam int FLAG_BROWNOUT = 2;
	localparam int FLAG_WATCHDOG = 3;
	localparam logic [7:0] CAUSE_RESET = 8'h01;

	// Interrupt sources and vectors
	localparam int NUM_IRQ          = 8;
	localparam logic [8:0] VEC_RESET = 9'h000;
	localparam logic [8:0] VEC_BASE  = 9'h001;

	// Sequencer states
	typedef enum logic [1:0] {
		RVS_HOLD,
		RVS_OSC_WAIT,
		RVS_CLK_WAIT,
		RVS_RUN
	} rvs_state_e;

	// Interrupt request/answer carrier
	typedef struct packed {
		logic       take;
		logic [8:0] vector;
		logic [7:0] clear;
	} rvs_irq_s;

	// Whole module state
	typedef struct packed {
		rvs_state_e state;
		logic [16:0] osc_cnt;
		logic [4:0]  clk_cnt;
		logic [6:0]  pin_cnt;
		logic        pin_rst;
		logic        osc_d1;
		logic        osc_d2;
		logic        osc_d3;
		logic        pin_d1;
		logic        pin_d2;
		logic        por_d1;
		logic        por_d2;
		logic        bo_d1;
		logic        bo_d2;
		logic        wdt_d;
		logic        wake_pend;
		logic        gie;
		logic [7:0]  cause;
		logic        core_rst_b;
		logic        io_init;
		logic [8:0]  fetch_addr;
		logic        fetch_load;
		rvs_irq_s    irq;
		logic [1:0]  sel_cap;
		logic        bo_lvl;
	} rvs_state_s;

endpackage

// *** rtl/rvs_sequencer.sv ***
// Purpose: Reset combiner, start-up delay and interrupt vector arbiter
// Assumes: Analog detectors and the reset pin are asynchronous levels; the
//          watchdog pulse, wake request and interrupt lines are core_clk logic
// Notes:   Register file is not touched here; only io_init drives peripherals
`timescale 1ns/1ps
module rvs_sequencer
	import rvs_pkg::*;
#(
	parameter int OSC_LONG  = rvs_pkg::OSC_CYC_LONG,
	parameter int OSC_MID   = rvs_pkg::OSC_CYC_MID
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_b,
	// Reset sources, watchdog oscillator and wake request
	input  wire logic                 reset_pin_b,
	input  wire logic                 powerup_ok,
	input  wire logic                 brownout_low,
	input  wire logic                 watchdog_pulse,
	input  wire logic                 wdt_osc,
	input  wire logic                 wake_powerdown,
	// Fuses
	input  wire logic [1:0]           startup_delay_select,
	input  wire logic                 brownout_enable_fuse,
	input  wire logic                 brownout_level_fuse,
	// Interrupt side
	input  wire logic [NUM_IRQ-1:0]   irq_pending,
	input  wire logic [NUM_IRQ-1:0]   irq_enable,
	input  wire logic                 gie_set,
	input  wire logic                 gie_clear,
	input  wire logic                 reti,
	input  wire logic                 irq_ready,
	// Cause register write
	input  wire logic                 cause_wr,
	input  wire logic [7:0]           cause_wdata,
	// Outputs to core
	output logic                      core_rst_b,
	output logic                      io_init,
	output logic [8:0]                fetch_addr,
	output logic                      fetch_load,
	output rvs_pkg::rvs_irq_s         irq_out,
	output logic                      gie,
	output logic [7:0]                reset_cause_register,
	output logic                      brownout_level_high
);
	import rvs_pkg::*;

	rvs_state_s st_reg;
	rvs_state_s st_next;

	// Parameter sanity, refused at elaboration; counts must fit the 17-bit counter
	if (OSC_LONG < 33 || OSC_LONG > 131071 ||
	    OSC_MID < 33 || OSC_MID > OSC_LONG) begin : g_bad_osc
		$error("rvs_sequencer: oscillator counts out of range");
	end

	// Combined live sources and osc tick
	logic       pin_low;
	logic       por_low;
	logic       bo_act;
	logic       wdt_fall;
	logic       osc_tick;
	logic       any_src;
	logic [16:0] osc_target;
	logic [1:0] sel;
	logic [7:0] ok_mask;
	logic [3:0] win_idx;
	logic       win_any;

	always_comb begin
		pin_low  = !st_reg.pin_d2;
		por_low  = !st_reg.por_d2;
		bo_act   = st_reg.bo_d2 && !brownout_enable_fuse;
		wdt_fall = st_reg.wdt_d && !watchdog_pulse;
		osc_tick = st_reg.osc_d2 && !st_reg.osc_d3;
		any_src  = st_reg.pin_rst || por_low || bo_act || watchdog_pulse;
		sel      = st_reg.sel_cap;
	end

	// Oscillator cycle target from the latched select
	always_comb begin
		case (sel)
			SEL_LONG_A, SEL_LONG_B: osc_target = 17'(OSC_LONG);
			SEL_MID:                osc_target = 17'(OSC_MID);
			SEL_SHORT:              osc_target = brownout_enable_fuse ?
			                        17'(OSC_CYC_SHORT) : 17'(OSC_CYC_SHORT_BO);
			default:                osc_target = 17'(OSC_LONG);
		endcase
	end

	// Priority pick: lowest index that is pending, enabled and global on
	always_comb begin
		ok_mask = irq_pending & irq_enable & {NUM_IRQ{st_reg.gie}};
		win_idx = 4'h0;
		win_any = 1'b0;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (ok_mask[i]) begin
				win_idx = 4'(i);
				win_any = 1'b1;
			end
		end
	end

	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.osc_d1 = wdt_osc;
		st_next.osc_d2 = st_reg.osc_d1;
		st_next.osc_d3 = st_reg.osc_d2;
		st_next.pin_d1 = reset_pin_b;
		st_next.pin_d2 = st_reg.pin_d1;
		st_next.por_d1 = powerup_ok;
		st_next.por_d2 = st_reg.por_d1;
		st_next.bo_d1  = brownout_low;
		st_next.bo_d2  = st_reg.bo_d1;
		st_next.wdt_d  = watchdog_pulse;
		st_next.bo_lvl = !brownout_level_fuse;
		st_next.fetch_load = 1'b0;
		st_next.irq.take   = 1'b0;
		st_next.irq.clear  = 8'h00;

		// Pin low must persist past the minimum width before it counts
		if (pin_low) begin
			if (st_reg.pin_cnt >= 7'(PIN_MIN_CYC))
				st_next.pin_rst = 1'b1;
			else
				st_next.pin_cnt = st_reg.pin_cnt + 7'h01;
		end else begin
			st_next.pin_cnt = 7'h00;
			st_next.pin_rst = 1'b0;
		end

		// Cause flags: software writes zero to clear, hardware set wins
		if (cause_wr)
			st_next.cause[3:0] = st_reg.cause[3:0] & cause_wdata[3:0];
		if (st_reg.pin_rst)
			st_next.cause[FLAG_PIN] = 1'b1;
		if (bo_act)
			st_next.cause[FLAG_BROWNOUT] = 1'b1;
		if (watchdog_pulse)
			st_next.cause[FLAG_WATCHDOG] = 1'b1;
		if (por_low)
			st_next.cause = CAUSE_RESET;
		st_next.cause[7:4] = 4'h0;

		// Global enable: taken interrupt clears, return or software sets
		if (gie_set || reti)
			st_next.gie = 1'b1;
		if (gie_clear)
			st_next.gie = 1'b0;

		if (wake_powerdown && st_reg.state == RVS_RUN)
			st_next.wake_pend = 1'b1;

		case (st_reg.state)
			RVS_HOLD: begin
				st_next.core_rst_b = 1'b0;
				st_next.io_init    = 1'b1;
				st_next.gie        = 1'b0;
				st_next.osc_cnt    = 17'h00000;
				st_next.clk_cnt    = 5'h00;
				if (!any_src && !wdt_fall) begin
					st_next.sel_cap = startup_delay_select;
					st_next.state   = RVS_OSC_WAIT;
				end
			end
			RVS_OSC_WAIT: begin
				if (any_src) begin
					st_next.state = RVS_HOLD;
				end else if (st_reg.osc_cnt >= osc_target) begin
					st_next.state = RVS_CLK_WAIT;
				end else if (osc_tick) begin
					st_next.osc_cnt = st_reg.osc_cnt + 17'h00001;
				end
			end
			RVS_CLK_WAIT: begin
				if (any_src) begin
					// Wake path runs with the core out of reset, so drop it now
					st_next.state      = RVS_HOLD;
					st_next.core_rst_b = 1'b0;
					st_next.io_init    = 1'b1;
				end else if (st_reg.clk_cnt == 5'(CLK_COUNT_CYC - 1)) begin
					st_next.state      = RVS_RUN;
					st_next.core_rst_b = 1'b1;
					st_next.io_init    = 1'b0;
					st_next.fetch_addr = VEC_RESET;
					st_next.fetch_load = 1'b1;
					st_next.wake_pend  = 1'b0;
				end else begin
					st_next.clk_cnt = st_reg.clk_cnt + 5'h01;
				end
			end
			RVS_RUN: begin
				if (any_src) begin
					st_next.state      = RVS_HOLD;
					st_next.core_rst_b = 1'b0;
					st_next.io_init    = 1'b1;
				end else if (st_reg.wake_pend) begin
					st_next.clk_cnt   = 5'h00;
					st_next.state     = RVS_CLK_WAIT;
					st_next.wake_pend = 1'b0;
				end else if (win_any && irq_ready) begin
					st_next.irq.take       = 1'b1;
					st_next.irq.vector     = VEC_BASE + 9'(win_idx);
					st_next.irq.clear      = 8'h01 << win_idx;
					st_next.fetch_addr     = VEC_BASE + 9'(win_idx);
					st_next.fetch_load     = 1'b1;
					st_next.gie            = 1'b0;
				end
			end
			default: st_next.state = RVS_HOLD;
		endcase
	end

	// State register; working registers live elsewhere and are untouched
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg            <= '0;
			st_reg.state      <= RVS_HOLD;
			st_reg.io_init    <= 1'b1;
			st_reg.cause      <= CAUSE_RESET;
			st_reg.sel_cap    <= SEL_RESET;
			st_reg.pin_d1     <= 1'b1;
			st_reg.pin_d2     <= 1'b1;
			st_reg.por_d1     <= 1'b1;
			st_reg.por_d2     <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flops
	always_comb begin
		core_rst_b           = st_reg.core_rst_b;
		io_init              = st_reg.io_init;
		fetch_addr           = st_reg.fetch_addr;
		fetch_load           = st_reg.fetch_load;
		irq_out              = st_reg.irq;
		gie                  = st_reg.gie;
		reset_cause_register = st_reg.cause;
		brownout_level_high  = st_reg.bo_lvl;
	end

endmodule

// *** sim/rvs_seq_properties.sv ***
// Purpose: Port checks for the reset and vector sequencer
// Assumes: One clock domain
// Notes:   Bound from the bench top
`timescale 1ns/1ps
module rvs_seq_props
	import rvs_pkg::*;
(
	// Clock and reset
	input wire logic              core_clk,
	input wire logic              rst_b,
	// Inputs watched
	input wire logic              reset_pin_b,
	input wire logic              powerup_ok,
	input wire logic              watchdog_pulse,
	input wire logic [7:0]        irq_pending,
	input wire logic [7:0]        irq_enable,
	input wire logic              gie_set,
	input wire logic              reti,
	// Outputs watched
	input wire logic              core_rst_b,
	input wire logic [8:0]        fetch_addr,
	input wire logic              fetch_load,
	input wire rvs_pkg::rvs_irq_s irq_out,
	input wire logic              gie,
	input wire logic [7:0]        reset_cause_register
);
	logic [6:0] low_cnt;
	wire  [7:0] armed = irq_pending & irq_enable;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// Cycles the reset pin has stayed low, saturating
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt <= 7'h00;
		end else begin
			low_cnt <= reset_pin_b ? 7'h00 : low_cnt + {6'h00, low_cnt != 7'h7F};
		end
	end
	// Interrupt acceptance, vector and priority
	property p_take;
		irq_out.take |-> ($past(gie) || $past(gie, 2)) && $past(core_rst_b);
	endproperty
	a_take: assert property (p_take) else $error("take without enable");
	property p_vec;
		irq_out.take |-> irq_out.vector inside {[9'h001:9'h008]}
			&& irq_out.clear == 8'h01 << (irq_out.vector - 9'h001);
	endproperty
	a_vec: assert property (p_vec) else $error("bad vector or clear");
	property p_prio;
		irq_out.take |-> ($past(armed) & irq_out.clear) != 8'h00
			&& ($past(armed) & (irq_out.clear - 8'h01)) == 8'h00;
	endproperty
	a_prio: assert property (p_prio) else $error("lower vector skipped");
	// Global enable handling
	property p_gie_off;
		irq_out.take && !gie_set && !reti |=> !gie;
	endproperty
	a_gie_off: assert property (p_gie_off) else $error("enable kept after take");
	property p_reti;
		reti && core_rst_b |=> gie;
	endproperty
	a_reti: assert property (p_reti) else $error("return left enable off");
	// Reset entry and release
	property p_release;
		$rose(core_rst_b) |-> fetch_load && fetch_addr == VEC_RESET && !$past(core_rst_b, 18);
	endproperty
	a_release: assert property (p_release) else $error("bad release");
	property p_por;
		!powerup_ok |-> ##[0:4] !core_rst_b;
	endproperty
	a_por: assert property (p_por) else $error("supply loss not reset");
	property p_pin;
		low_cnt == 7'h46 |-> ##[0:3] !core_rst_b;
	endproperty
	a_pin: assert property (p_pin) else $error("long pin low not reset");
	property p_wdt;
		watchdog_pulse |-> ##[1:4] (!core_rst_b && reset_cause_register[FLAG_WATCHDOG]);
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog not reset");
	// Main scenarios reached
	c_take: cover property (irq_out.take);
	c_release: cover property ($rose(core_rst_b));
	c_wdt: cover property (watchdog_pulse);
endmodule

// *** sim/rvs_core_model.sv ***
// Purpose: Core and watchdog oscillator model facing the sequencer
// Assumes: Handler returns three clocks after a taken interrupt
// Notes:   Oscillator ticks every six clocks; core is sometimes not ready
`timescale 1ns/1ps
module rvs_core_model
	import rvs_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	// From the sequencer
	input  wire rvs_pkg::rvs_irq_s irq_out,
	// To the sequencer
	output logic                   wdt_osc,
	output logic                   irq_ready,
	output logic                   reti
);
	logic [2:0] div;
	logic [1:0] ret_cnt;
	// Oscillator divider and delayed handler return
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div     <= 3'h0;
			ret_cnt <= 2'h0;
		end else begin
			div     <= (div == 3'h5) ? 3'h0 : div + 3'h1;
			ret_cnt <= irq_out.take ? 2'h3 : ret_cnt - {1'b0, ret_cnt != 2'h0};
		end
	end
	// Outputs
	assign wdt_osc   = div < 3'h3;
	assign irq_ready = div != 3'h4;
	assign reti      = ret_cnt == 2'h1;
endmodule

// *** sim/tb_reset_and_vector_sequencer.sv ***
// Purpose: Self-checking bench for the reset and vector sequencer
// Assumes: Oscillator model ticks every six clocks; long counts shortened
// Notes:   Random interrupt mixes from a fixed seed
`timescale 1ns/1ps
module tb_reset_and_vector_sequencer;
	import rvs_pkg::*;
	localparam int OL = 64;
	localparam int OM = 40;
	logic core_clk = 1'b0, rst_b = 1'b0, reset_pin_b = 1'b1, powerup_ok = 1'b0;
	logic brownout_low = 1'b0, watchdog_pulse = 1'b0, gie_set = 1'b0, gie_clear = 1'b0;
	logic cause_wr = 1'b0, brownout_enable_fuse = 1'b1, brownout_level_fuse = 1'b1;
	logic wake_powerdown = 1'b0;
	logic [1:0] startup_delay_select = SEL_RESET;
	logic [7:0] irq_pending = 8'h00, irq_enable = 8'h00, cause_wdata = 8'h00;
	logic [7:0] reset_cause_register;
	logic wdt_osc, irq_ready, reti, core_rst_b, io_init, fetch_load, gie, brownout_level_high;
	logic [8:0] fetch_addr;
	rvs_irq_s irq_out;
	int num_errors = 0, cmp_count = 0;
	// Core clock, 8 ns period
	always #4 core_clk = ~core_clk;
	// Device and far side
	rvs_sequencer #(.OSC_LONG(OL), .OSC_MID(OM)) dut (.core_clk, .rst_b, .reset_pin_b,
		.powerup_ok, .brownout_low, .watchdog_pulse, .wdt_osc, .wake_powerdown,
		.startup_delay_select, .brownout_enable_fuse, .brownout_level_fuse, .irq_pending,
		.irq_enable, .gie_set, .gie_clear, .reti, .irq_ready, .cause_wr, .cause_wdata,
		.core_rst_b, .io_init, .fetch_addr, .fetch_load, .irq_out, .gie,
		.reset_cause_register, .brownout_level_high);
	rvs_core_model u_core (.core_clk, .rst_b, .irq_out, .wdt_osc, .irq_ready, .reti);
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Oscillator ticks of the start-up delay
	function automatic int osc_n(input logic [1:0] s, input logic off);
		return (s == SEL_MID) ? OM : (s != SEL_SHORT) ? OL : off ? OSC_CYC_SHORT : OSC_CYC_SHORT_BO;
	endfunction
	// Lowest armed vector, zero when none
	function automatic logic [8:0] first_vec(input logic [7:0] v);
		first_vec = 9'h000;
		for (int b = 7; b >= 0; b--) begin
			if (v[b]) begin
				first_vec = 9'(b + 1);
			end
		end
	endfunction
	// Wait for release, neither early nor late; zero means no reset may happen
	task automatic wait_rel(input int n);
		int k;
		k = 0;
		while (core_rst_b !== 1'b1 && k < 6 * n + 60) begin
			@(negedge core_clk);
			k++;
		end
		check("release", 16'((n ? k >= 6 * n + 4 : k == 0) && core_rst_b === 1'b1), 16'h0001);
		if (core_rst_b !== 1'b1) give_verdict();
	endtask
	// Main sequence
	initial begin
		int i;
		int n;
		logic off;
		logic [7:0] p;
		logic [7:0] e;
		logic [8:0] v;
		void'($urandom(64679));
		cyc(12);
		check("io init", 16'(io_init), 16'h0001);
		rst_b <= 1'b1;
		for (i = 0; i < 8; i++) begin
			cyc(1);
			startup_delay_select <= 2'(i);
			brownout_enable_fuse <= i[2];
			brownout_level_fuse <= i[0];
			powerup_ok <= 1'b0;
			cyc(4);
			powerup_ok <= 1'b1;
			wait_rel(osc_n(2'(i), i[2]));
			check("por cause", 16'(reset_cause_register), 16'h0001);
			check("level", 16'(brownout_level_high), 16'(!i[0]));
			cyc(1);
			brownout_low <= 1'b1;
			cyc(8);
			brownout_low <= 1'b0;
			wait_rel(i[2] ? 0 : osc_n(2'(i), 1'b0));
			check("bo cause", 16'(reset_cause_register), i[2] ? 16'h0001 : 16'h0005);
		end
		// Clear flags, then pin and watchdog resets
		cyc(1);
		cause_wr <= 1'b1;
		cyc(1);
		cause_wr <= 1'b0;
		@(negedge core_clk);
		check("cleared", 16'(reset_cause_register), 16'h0000);
		cyc(1);
		reset_pin_b <= 1'b0;
		cyc(70);
		reset_pin_b <= 1'b1;
		wait_rel(OSC_CYC_SHORT);
		check("pin cause", 16'(reset_cause_register), 16'h0002);
		cyc(1);
		watchdog_pulse <= 1'b1;
		cyc(1);
		watchdog_pulse <= 1'b0;
		cyc(4);
		wait_rel(OSC_CYC_SHORT);
		check("wdt cause", 16'(reset_cause_register), 16'h000A);
		// Wake from power-down: only the clock-counted part, core stays running
		cyc(1);
		wake_powerdown <= 1'b1;
		cyc(1);
		wake_powerdown <= 1'b0;
		n = 0;
		while (fetch_load !== 1'b1 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		check("wake", 16'(n >= CLK_COUNT_CYC && n <= CLK_COUNT_CYC + 2 && core_rst_b === 1'b1), 16'h0001);
		// Corner and random interrupt mixes, global enable sometimes off
		for (i = 0; i < 40; i++) begin
			off = i > 8 && i % 5 == 4;
			p = (i < 9) ? 8'h01 << i : 8'($urandom());
			e = (i < 9) ? 8'hFF : 8'($urandom());
			v = off ? 9'h000 : first_vec(p & e);
			cyc(1);
			gie_set <= !off;
			gie_clear <= off;
			cyc(1);
			gie_set <= 1'b0;
			gie_clear <= 1'b0;
			irq_pending <= p;
			irq_enable <= e;
			n = 0;
			while (irq_out.take !== 1'b1 && n < 30) begin
				@(negedge core_clk);
				n++;
			end
			check("vector", 16'(irq_out.take ? irq_out.vector : 9'h000), 16'(v));
			check("clear", 16'(irq_out.clear), 16'(v ? 8'h01 << (v - 9'h001) : 8'h00));
			@(negedge core_clk);
			check("gie", 16'(gie), 16'(v == 9'h000 && !off));
			cyc(1);
			irq_pending <= 8'h00;
			cyc(6);
		end
		give_verdict();
	end
	// Cut a hung run short
	initial begin
		cyc(90000);
		check("timeout", 16'h0000, 16'h0001);
		give_verdict();
	end
endmodule
// Property checker on the sequencer ports
bind rvs_sequencer rvs_seq_props u_props (.core_clk, .rst_b, .reset_pin_b, .powerup_ok,
	.watchdog_pulse, .irq_pending, .irq_enable, .gie_set, .reti, .core_rst_b, .fetch_addr,
	.fetch_load, .irq_out, .gie, .reset_cause_register);
